// ### src/psc_pkg.sv
// Package: indices, field layout and reset values of the packet statistics counters
package psc_pkg;
   // Counter, word and index widths
   localparam int unsigned CNT_W = 48;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned IDX_W = 5;
   // Address port field layout
   localparam int unsigned ADDR_READ_BIT = 15;
   localparam int unsigned ADDR_IDX_LSB = 0;
   // Advanced register indices
   localparam logic [IDX_W-1:0] IDX_GOOD_RX_HIGH = 5'h02;
   localparam logic [IDX_W-1:0] IDX_GOOD_RX_MID = 5'h03;
   localparam logic [IDX_W-1:0] IDX_GOOD_RX_LOW = 5'h04;
   localparam logic [IDX_W-1:0] IDX_CRC_HIGH = 5'h05;
   localparam logic [IDX_W-1:0] IDX_CRC_MID = 5'h06;
   localparam logic [IDX_W-1:0] IDX_CRC_LOW = 5'h07;
   localparam logic [IDX_W-1:0] IDX_RXERR_FRAME = 5'h08;
   localparam logic [IDX_W-1:0] IDX_RXERR_IDLE = 5'h09;
   localparam logic [IDX_W-1:0] IDX_TX_HIGH = 5'h0a;
   localparam logic [IDX_W-1:0] IDX_TX_MID = 5'h0b;
   // Reset and unmapped read values
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [WORD_W-1:0] UNMAPPED_WORD = 16'h0000;
   typedef logic [WORD_W-1:0] psc_word_t;
   typedef logic [IDX_W-1:0] psc_idx_t;
endpackage

// ### src/psc_cnt_if.sv
// Interface: increment, clear and value of one statistics counter
`timescale 1ns/100ps
`default_nettype none
interface psc_cnt_if #(parameter int unsigned W = 48);
   logic inc;
   logic clr;
   logic [W-1:0] value;
   modport ctr (input inc, input clr, output value);
   modport user (output inc, output clr, input value);
endinterface
`default_nettype wire

// ### src/psc_counter.sv
// Module: one clear-on-demand event counter
`timescale 1ns/100ps
`default_nettype none
module psc_counter #(
   parameter int unsigned W = 48
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Counter port
   psc_cnt_if.ctr cnt
);
   import psc_pkg::*;

   logic [W-1:0] nxt_value;

   always_comb
   begin
      if (cnt.clr)
      begin
         // Event in the clearing cycle is kept
         nxt_value = cnt.inc ? W'(1) : '0;
      end
      else if (cnt.inc)
      begin
         nxt_value = cnt.value + W'(1);
      end
      else
      begin
         nxt_value = cnt.value;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         cnt.value <= '0;
      end
      else
      begin
         cnt.value <= nxt_value;
      end
   end
endmodule
`default_nettype wire

// ### src/psc_rx_ctl_decode.sv
// Module: receive control pin decode and error edge detection
`timescale 1ns/100ps
`default_nettype none
module psc_rx_ctl_decode (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Receive control pin, rising and falling half samples
   input wire logic rxCtlRise,
   input wire logic rxCtlFall,
   // Error edge events
   output logic errInFrame,
   output logic errInIdle
);
   import psc_pkg::*;

   logic [1:0] syncA_ff;
   logic [1:0] syncB_ff;
   logic rxDv;
   logic rxEr;
   logic rxErPrev_ff;
   logic errRise;

   // Two-stage synchronisers
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         syncA_ff <= 2'h0;
         syncB_ff <= 2'h0;
      end
      else
      begin
         syncA_ff <= {syncA_ff[0], rxCtlRise};
         syncB_ff <= {syncB_ff[0], rxCtlFall};
      end
   end

   // Valid on rising half, error is the xor of both halves
   assign rxDv = syncA_ff[1];
   assign rxEr = syncA_ff[1] ^ syncB_ff[1];

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         rxErPrev_ff <= 1'b0;
      end
      else
      begin
         rxErPrev_ff <= rxEr;
      end
   end

   assign errRise = rxEr && !rxErPrev_ff;
   assign errInFrame = errRise && rxDv;
   assign errInIdle = errRise && !rxDv;
endmodule
`default_nettype wire

// ### src/psc_stat_counters.sv
// Module: packet statistics counters behind the advanced register port
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Good receive packets counted in 48 bits, shown as high, mid, low words.
// - Reading the good-receive high word returns it, then clears all 48 bits.
// - CRC checker errors counted in 48 bits, shown as three words.
// - Reading the CRC high word returns it, then clears the whole counter.
// - Rising receive errors while data valid is high are counted in 16 bits.
// - Rising receive errors while data valid is low are counted separately.
// - Receive valid and error both come from the receive control pin.
// - Transmitted packets counted in 48 bits; high and mid words readable.
// - Reading the transmit high word returns it, then clears the counter.
// - Writes to the counter words are ignored.
module psc_stat_counters (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Advanced register address port and read data port
   input wire logic addrPortWr,
   input wire psc_pkg::psc_word_t addrPortData,
   output psc_pkg::psc_word_t rdDataPort,
   // Traffic events from the datapath
   input wire logic goodRxPkt,
   input wire logic crc_error_count,
   input wire logic tx_packet_count,
   // Receive control pin samples
   input wire logic rxCtlRise,
   input wire logic rxCtlFall
);
   import psc_pkg::*;

   psc_cnt_if #(.W(CNT_W)) goodIf ();
   psc_cnt_if #(.W(CNT_W)) crcIf ();
   psc_cnt_if #(.W(CNT_W)) txIf ();
   psc_cnt_if #(.W(WORD_W)) frameErrIf ();
   psc_cnt_if #(.W(WORD_W)) idleErrIf ();

   logic addrRead;
   psc_idx_t rdIdx;
   psc_word_t nxt_rdData;
   psc_word_t rdData_ff;
   logic errInFrame;
   logic errInIdle;

   // Word of a 48-bit counter, 0 low, 1 mid, 2 high
   function automatic psc_word_t word_of(input logic [CNT_W-1:0] v, input int unsigned sel);
      psc_word_t w;
      w = v[sel*WORD_W +: WORD_W];
      return w;
   endfunction

   // Only a write with the read bit set starts an access
   assign addrRead = addrPortWr && addrPortData[ADDR_READ_BIT];
   assign rdIdx = addrPortData[ADDR_IDX_LSB +: IDX_W];

   // Event counters
   psc_counter #(.W(CNT_W)) u_good (.ref_clk(ref_clk), .nrst(nrst), .cnt(goodIf.ctr));
   psc_counter #(.W(CNT_W)) u_crc (.ref_clk(ref_clk), .nrst(nrst), .cnt(crcIf.ctr));
   psc_counter #(.W(CNT_W)) u_tx (.ref_clk(ref_clk), .nrst(nrst), .cnt(txIf.ctr));
   psc_counter #(.W(WORD_W)) u_frameErr (.ref_clk(ref_clk), .nrst(nrst), .cnt(frameErrIf.ctr));
   psc_counter #(.W(WORD_W)) u_idleErr (.ref_clk(ref_clk), .nrst(nrst), .cnt(idleErrIf.ctr));

   psc_rx_ctl_decode u_rxDecode (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .rxCtlRise(rxCtlRise),
      .rxCtlFall(rxCtlFall),
      .errInFrame(errInFrame),
      .errInIdle(errInIdle)
   );

   assign goodIf.inc = goodRxPkt;
   assign crcIf.inc = crc_error_count;
   assign txIf.inc = tx_packet_count;
   assign frameErrIf.inc = errInFrame;
   assign idleErrIf.inc = errInIdle;

   // Clear only on high word or 16-bit counter reads
   assign goodIf.clr = addrRead && (rdIdx == IDX_GOOD_RX_HIGH);
   assign crcIf.clr = addrRead && (rdIdx == IDX_CRC_HIGH);
   assign txIf.clr = addrRead && (rdIdx == IDX_TX_HIGH);
   assign frameErrIf.clr = addrRead && (rdIdx == IDX_RXERR_FRAME);
   assign idleErrIf.clr = addrRead && (rdIdx == IDX_RXERR_IDLE);

   // Selected word, taken before any clear lands
   always_comb
   begin
      case (rdIdx)
         IDX_GOOD_RX_HIGH: nxt_rdData = word_of(goodIf.value, 2);
         IDX_GOOD_RX_MID: nxt_rdData = word_of(goodIf.value, 1);
         IDX_GOOD_RX_LOW: nxt_rdData = word_of(goodIf.value, 0);
         IDX_CRC_HIGH: nxt_rdData = word_of(crcIf.value, 2);
         IDX_CRC_MID: nxt_rdData = word_of(crcIf.value, 1);
         IDX_CRC_LOW: nxt_rdData = word_of(crcIf.value, 0);
         IDX_RXERR_FRAME: nxt_rdData = frameErrIf.value;
         IDX_RXERR_IDLE: nxt_rdData = idleErrIf.value;
         IDX_TX_HIGH: nxt_rdData = word_of(txIf.value, 2);
         IDX_TX_MID: nxt_rdData = word_of(txIf.value, 1);
         default: nxt_rdData = UNMAPPED_WORD;
      endcase
   end

   // Read data port holds the last read word
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         rdData_ff <= WORD_RST;
      end
      else if (addrRead)
      begin
         rdData_ff <= nxt_rdData;
      end
   end

   assign rdDataPort = rdData_ff;
endmodule
`default_nettype wire

// ### bench/psc_mac_model.sv
// Partner model: MAC side driving the receive control pin halves
`timescale 1ns/100ps
`default_nettype none
module psc_mac_model (
   // Receive state chosen by the bench
   input wire logic dv,
   input wire logic er,
   // Receive control pin halves
   output logic rxCtlRise,
   output logic rxCtlFall
);
   assign rxCtlRise = dv;
   assign rxCtlFall = dv ^ er;
endmodule
`default_nettype wire

// ### bench/psc_stat_counters_sva.sv
// Checker: assertions on the statistics counter ports
`timescale 1ns/100ps
`default_nettype none
module psc_stat_sva (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Register port
   input wire logic addrPortWr,
   input wire psc_pkg::psc_word_t addrPortData,
   input wire psc_pkg::psc_word_t rdDataPort,
   // Events
   input wire logic goodRxPkt,
   input wire logic crc_error_count,
   input wire logic tx_packet_count
);
   import psc_pkg::*;
   wire logic tk = addrPortWr && addrPortData[ADDR_READ_BIT];
   wire psc_idx_t ix = addrPortData[IDX_W-1:0];
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // Read of word a, event state in that cycle, then read of word b
   sequence s_pair(psc_idx_t a, psc_idx_t b, logic want, logic ev);
      tk && ix == a && ev == want ##1 tk && ix == b;
   endsequence
   property p_rst; $rose(nrst) |-> rdDataPort == WORD_RST; endproperty
   a_rst: assert property (p_rst) else $error("reset value");
   property p_hold; !tk |=> $stable(rdDataPort); endproperty
   a_hold: assert property (p_hold) else $error("data port moved");
   property p_unmap; tk && !(ix inside {[2:11]}) |=> rdDataPort == UNMAPPED_WORD; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped word");
   property p_clr_good;
      s_pair(IDX_GOOD_RX_HIGH, IDX_GOOD_RX_LOW, 1'b0, goodRxPkt) |=> rdDataPort == WORD_RST;
   endproperty
   a_clr_good: assert property (p_clr_good) else $error("good count kept");
   property p_clr_crc; s_pair(IDX_CRC_HIGH, IDX_CRC_LOW, 1'b0, crc_error_count) |=> rdDataPort == WORD_RST; endproperty
   a_clr_crc: assert property (p_clr_crc) else $error("crc count kept");
   property p_clr_tx; s_pair(IDX_TX_HIGH, IDX_TX_MID, 1'b0, tx_packet_count) |=> rdDataPort == WORD_RST; endproperty
   a_clr_tx: assert property (p_clr_tx) else $error("tx count kept");
   property p_low_keep;
      s_pair(IDX_GOOD_RX_LOW, IDX_GOOD_RX_LOW, 1'b0, goodRxPkt) |=> rdDataPort == $past(rdDataPort);
   endproperty
   a_low_keep: assert property (p_low_keep) else $error("low word moved");
   property p_low_inc;
      s_pair(IDX_GOOD_RX_LOW, IDX_GOOD_RX_LOW, 1'b1, goodRxPkt) |=> rdDataPort == $past(rdDataPort) + 16'h0001;
   endproperty
   a_low_inc: assert property (p_low_inc) else $error("low word step");
endmodule
bind psc_stat_counters psc_stat_sva chk (.ref_clk, .nrst, .addrPortWr, .addrPortData, .rdDataPort, .goodRxPkt,
   .crc_error_count, .tx_packet_count);
`default_nettype wire

// ### bench/psc_stat_counters_test.sv
// Testbench: statistics counters against a reference model
`timescale 1ns/100ps
`default_nettype none
module psc_stat_counters_test;
   import psc_pkg::*;
   logic ref_clk = 1'b0, nrst = 1'b0, addrPortWr = 1'b0, goodRxPkt = 1'b0, crc_error_count = 1'b0, tx_packet_count = 1'b0;
   logic dv = 1'b0, er = 1'b0, rxCtlRise, rxCtlFall, eP, e, t;
   psc_word_t addrPortData = WORD_RST, rdDataPort, expRd;
   logic [47:0] cnt [3];
   logic [15:0] errCnt [2];
   logic [1:0] p1, p2;
   // Software read order: low twice, mid, high, low again for good and CRC; unmapped, mid, high, mid for transmit; then both error counters
   psc_idx_t ord [16] = '{IDX_GOOD_RX_LOW, IDX_GOOD_RX_LOW, IDX_GOOD_RX_MID, IDX_GOOD_RX_HIGH, IDX_GOOD_RX_LOW,
      IDX_CRC_LOW, IDX_CRC_LOW, IDX_CRC_MID, IDX_CRC_HIGH, IDX_CRC_LOW, 5'h0c, IDX_TX_MID, IDX_TX_HIGH, IDX_TX_MID,
      IDX_RXERR_FRAME, IDX_RXERR_IDLE};
   int i, c, k, miscompares = 0, n_tests = 0;
   psc_stat_counters uut (.ref_clk, .nrst, .addrPortWr, .addrPortData, .rdDataPort, .goodRxPkt, .crc_error_count, .tx_packet_count,
      .rxCtlRise, .rxCtlFall);
   psc_mac_model mac (.dv, .er, .rxCtlRise, .rxCtlFall);
   always #20 ref_clk = ~ref_clk;
   // Reference model, stepped on the design's own edge
   always @(posedge ref_clk)
   begin
      i = int'(addrPortData[4:0]);
      t = addrPortWr && addrPortData[15];
      if (t && i inside {8, 9})
      begin
         expRd = errCnt[i - 8];
         errCnt[i - 8] = 16'h0;
      end
      else if (t && i inside {[2:7], 10, 11})
      begin
         c = i < 8 ? (i - 2) / 3 : 2;
         k = i < 8 ? 2 - (i - 2) % 3 : 12 - i;
         expRd = cnt[c][16 * k +: 16];
         if (k == 2)
            cnt[c] = 48'h0;
      end
      else if (t)
         expRd = UNMAPPED_WORD;
      cnt[0] += 48'(goodRxPkt);
      cnt[1] += 48'(crc_error_count);
      cnt[2] += 48'(tx_packet_count);
      e = ^p2;
      if (e && !eP)
         errCnt[p2[1] ? 0 : 1] += 16'h1;
      {eP, p2, p1} = {e, p1, rxCtlRise, rxCtlFall};
      if (!nrst)
      begin
         cnt = '{3{48'h0}};
         errCnt = '{2{16'h0}};
         {expRd, eP, p2, p1} = '0;
      end
   end
   task automatic chk(string name, psc_word_t exp, psc_word_t got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One port request with random traffic and receive state alongside
   task automatic rd(psc_idx_t idx, logic rdBit);
      @(negedge ref_clk);
      addrPortWr = 1'b1;
      addrPortData = {rdBit, 10'h000, idx};
      {goodRxPkt, crc_error_count, tx_packet_count, dv, er} = 5'($urandom);
      @(posedge ref_clk);
      #1 chk("rdDataPort", expRd, rdDataPort);
   endtask
   task automatic summarize;
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      void'($urandom(10821));
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      for (int j = 0; j < 520; j++) rd(ord[j % 16], 1'b1);
      for (int j = 0; j < 600; j++) rd(5'($urandom), 1'($urandom));
      @(negedge ref_clk);
      {addrPortWr, goodRxPkt, crc_error_count, tx_packet_count, dv, er} = 6'h00;
      nrst = 1'b0;
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      for (int j = 0; j < 16; j++) rd(ord[j], 1'b1);
      summarize();
   end
   // Cut a hang well past the expected run length
   initial
   begin
      #(40 * 4000);
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
